// >>> common/cmpc_pkg.sv
// Shared constants for the comparator control logic.
package cmpc_pkg;

	// ****************************************
	// Register indices; byte address is four times the index.
	// ****************************************
	localparam int ADDR_W = 8;
	localparam logic [5:0] IDX_STATUS = 6'h03;
	localparam logic [5:0] IDX_CTRL = 6'h07;
	localparam logic [5:0] IDX_PIN_DIR = 6'h08;
	localparam logic [5:0] IDX_IRQ_STATUS = 6'h09;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h0a;

	// ****************************************
	// Comparator control fields.
	// ****************************************
	localparam int CTL_RESULT = 7;
	localparam int CTL_DRIVE_OFF = 6;
	localparam int CTL_INVERT_SEL = 5;
	localparam int CTL_CLOCK_SEL = 4;
	localparam int CTL_POWER_ON = 3;
	localparam int CTL_NEG_REF = 2;
	localparam int CTL_POS_REF = 1;
	localparam int CTL_WAKE_DIS = 0;
	localparam logic [7:0] CTL_RESET = 8'hff;
	localparam logic [7:0] CTL_WMASK = 8'h7f;

	// ****************************************
	// Core status flags, pin direction and interrupts.
	// ****************************************
	localparam int STAT_PIN_WAKE = 7;
	localparam int STAT_CMP_WAKE = 6;
	localparam int PIN_DIR_W = 4;
	localparam logic [3:0] PIN_DIR_RESET = 4'hf;
	localparam int PIN_DIR_RESULT_BIT = 2;
	localparam int IRQ_W = 2;
	localparam int IRQ_WAKE = 0;
	localparam int IRQ_CHANGE = 1;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// ****************************************
	// Bus responses and timer clock sources.
	// ****************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		SRC_INSTR = 2'b00,
		SRC_RESULT = 2'b01,
		SRC_EXT_PIN = 2'b10
	} cmpc_src_e;

endpackage

// >>> src/cmpc_clk_mux.sv
// Timer clock source selection with a registered output.
`timescale 1ns/1ps
module cmpc_clk_mux (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	// Selection
	input wire logic i_timer_clock_select,
	input wire logic i_comparator_clock_select,
	input wire logic i_result_pin_drive_off,
	input wire logic i_powered,
	// Sources
	input wire logic i_instr_tick,
	input wire logic i_result,
	input wire logic i_ext_pin,
	// Outputs
	output logic o_timer_clk,
	output cmpc_pkg::cmpc_src_e o_src
);
	cmpc_pkg::cmpc_src_e src_d, src_q;
	logic clk_d, clk_q;

	always_comb begin
		// A switched-off comparator leaves the plain external pin selection in charge.
		if (!i_timer_clock_select) begin
			src_d = cmpc_pkg::SRC_INSTR;
		end else if (!i_powered || (i_comparator_clock_select && i_result_pin_drive_off)) begin
			src_d = cmpc_pkg::SRC_EXT_PIN;
		end else begin
			src_d = cmpc_pkg::SRC_RESULT;
		end
		unique case (src_d)
			cmpc_pkg::SRC_INSTR: clk_d = i_instr_tick;
			cmpc_pkg::SRC_RESULT: clk_d = i_result;
			cmpc_pkg::SRC_EXT_PIN: clk_d = i_ext_pin;
			default: clk_d = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			src_q <= cmpc_pkg::SRC_INSTR;
			clk_q <= 1'b0;
		end else if (i_ce) begin
			src_q <= src_d;
			clk_q <= clk_d;
		end
	end

	assign o_timer_clk = clk_q;
	assign o_src = src_q;
endmodule

// >>> src/cmpc_axil.sv
// AXI4-Lite slave front end turning bus beats into register strobes.
`timescale 1ns/1ps
module cmpc_axil (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	// Write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register side
	output logic o_wr_en,
	output logic [5:0] o_wr_idx,
	output logic [7:0] o_wr_data,
	input wire logic i_wr_hit,
	output logic o_rd_en,
	output logic [5:0] o_rd_idx,
	input wire logic [7:0] i_rd_data,
	input wire logic i_rd_hit
);
	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic w_strb_q, w_strb_d;
	logic [5:0] aw_idx_q, aw_idx_d;
	logic [7:0] w_data_q, w_data_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic do_wr, do_rd;

	// Only byte lane 0 carries register data; other lanes are ignored.
	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		aw_idx_d = aw_idx_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (s_axi_awvalid && !aw_have_q) begin
			aw_have_d = 1'b1;
			aw_idx_d = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && !w_have_q) begin
			w_have_d = 1'b1;
			w_data_d = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
			// The strobe is held with the data; the bus may change it once the beat is taken.
			w_strb_d = s_axi_wstrb[0];
		end
		do_wr = aw_have_q && w_have_q && !bvalid_q && w_strb_q;
		if (aw_have_q && w_have_q && !bvalid_q) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = i_wr_hit ? cmpc_pkg::RESP_OKAY : cmpc_pkg::RESP_DECERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		do_rd = s_axi_arvalid && !rvalid_q;
		if (do_rd) begin
			rvalid_d = 1'b1;
			rdata_d = {24'h000000, i_rd_data};
			rresp_d = i_rd_hit ? cmpc_pkg::RESP_OKAY : cmpc_pkg::RESP_DECERR;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_idx_q <= 6'h00;
			w_data_q <= 8'h00;
			w_strb_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			rvalid_q <= 1'b0;
			rresp_q <= 2'h0;
			rdata_q <= 32'h00000000;
		end else if (i_ce) begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			aw_idx_q <= aw_idx_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready = !w_have_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign o_wr_en = do_wr && i_ce;
	assign o_wr_idx = aw_idx_q;
	assign o_wr_data = w_data_q;
	assign o_rd_en = do_rd && i_ce;
	assign o_rd_idx = s_axi_araddr[7:2];
endmodule

// >>> src/cmpc_top.sv
// Comparator control logic: result register, wake detection, pin and timer steering.
//
// How it works
// - Timer clock select 0 counts instruction cycles; 1 takes the external pin when the comparator is off or clock select and drive-off are 1, else the result.
// - With invert select at 1 the result is high when the positive input is above the negative one; at 0 it is the inverse.
// - The result is a read-only bit of the control register that writes leave alone, and it also feeds the timer mux.
// - The wake flag sets only with wake enabled, a latching read done, the device asleep and a result change.
// - The wake flag stays set until software clears it or a reset does.
// - An enabled comparator and its change detection keep running through sleep.
// - Reset loads the control register with all ones, every shared pin analog.
// - The comparator is held powered down while reset is asserted.
// - With drive-off at 0 the result drives the output pin, overriding its direction bit.
// - A switched-off comparator steers no pin and no clock; the other controls decide.
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module cmpc_top (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	// AXI4-Lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog comparator
	input wire logic i_cmp_raw,
	output logic o_comparator_power_on,
	output logic o_positive_reference_select,
	output logic o_negative_reference_select,
	output logic o_analog_pins,
	// Core and timer
	input wire logic i_sleep,
	input wire logic i_pin_change_wake,
	input wire logic i_timer_clock_select,
	input wire logic i_instr_tick,
	input wire logic i_external_timer_clock_pin,
	output logic o_timer_clk,
	// Comparator output pin
	input wire logic i_pin_port_data,
	output logic o_comparator_output_pin_o,
	output logic o_comparator_output_pin_oe,
	// Interrupt
	output logic o_irq
);
	// ****************************************
	// Declarations
	// ****************************************
	logic wr_en, rd_en, wr_hit, rd_hit;
	logic [5:0] wr_idx, rd_idx;
	logic [7:0] wr_data, rd_data;
	logic [7:0] ctl_q, ctl_d;
	logic [cmpc_pkg::PIN_DIR_W-1:0] pin_dir_q, pin_dir_d;
	logic result_q, result_d, latched_q, latched_d, armed_q, armed_d;
	logic cmp_wake_q, cmp_wake_d, pin_wake_q, pin_wake_d;
	logic [cmpc_pkg::IRQ_W-1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d, irq_ev;
	logic power_q, power_d, pref_q, pref_d, nref_q, nref_d, analog_q, analog_d;
	logic pin_o_q, pin_o_d, pin_oe_q, pin_oe_d, irq_q, irq_d;
	logic powered, wake_cond, ctrl_wr, status_wr;
	cmpc_pkg::cmpc_src_e src_unused;

	// ****************************************
	// Bus front end
	// ****************************************
	cmpc_axil u_axil (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.o_wr_en(wr_en),
		.o_wr_idx(wr_idx),
		.o_wr_data(wr_data),
		.i_wr_hit(wr_hit),
		.o_rd_en(rd_en),
		.o_rd_idx(rd_idx),
		.i_rd_data(rd_data),
		.i_rd_hit(rd_hit)
	);

	function automatic logic idx_hit(input logic [5:0] idx);
		idx_hit = (idx == cmpc_pkg::IDX_STATUS) || (idx == cmpc_pkg::IDX_CTRL) ||
			(idx == cmpc_pkg::IDX_PIN_DIR) || (idx == cmpc_pkg::IDX_IRQ_STATUS) ||
			(idx == cmpc_pkg::IDX_IRQ_MASK);
	endfunction

	assign wr_hit = idx_hit(wr_idx);
	assign rd_hit = idx_hit(rd_idx);
	assign ctrl_wr = wr_en && (wr_idx == cmpc_pkg::IDX_CTRL);
	assign status_wr = wr_en && (wr_idx == cmpc_pkg::IDX_STATUS);

	// Core flags other than the two wake flags live in the core and read as zero here.
	always_comb begin
		rd_data = 8'h00;
		unique case (rd_idx)
			cmpc_pkg::IDX_STATUS: begin
				rd_data[cmpc_pkg::STAT_PIN_WAKE] = pin_wake_q;
				rd_data[cmpc_pkg::STAT_CMP_WAKE] = cmp_wake_q;
			end
			cmpc_pkg::IDX_CTRL: rd_data = {result_q, ctl_q[6:0]};
			cmpc_pkg::IDX_PIN_DIR: rd_data = {4'h0, pin_dir_q};
			cmpc_pkg::IDX_IRQ_STATUS: rd_data = {6'h00, irq_st_q};
			cmpc_pkg::IDX_IRQ_MASK: rd_data = {6'h00, irq_mask_q};
			default: rd_data = 8'h00;
		endcase
	end

	// ****************************************
	// Control and direction registers
	// ****************************************
	always_comb begin
		ctl_d = ctl_q;
		pin_dir_d = pin_dir_q;
		irq_mask_d = irq_mask_q;
		if (ctrl_wr) begin
			// The result bit is never written by software.
			ctl_d = (ctl_q & ~cmpc_pkg::CTL_WMASK) | (wr_data & cmpc_pkg::CTL_WMASK);
		end
		if (wr_en && (wr_idx == cmpc_pkg::IDX_PIN_DIR)) begin
			pin_dir_d = wr_data[cmpc_pkg::PIN_DIR_W-1:0];
		end
		if (wr_en && (wr_idx == cmpc_pkg::IDX_IRQ_MASK)) begin
			irq_mask_d = wr_data[cmpc_pkg::IRQ_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			ctl_q <= cmpc_pkg::CTL_RESET;
			pin_dir_q <= cmpc_pkg::PIN_DIR_RESET;
			irq_mask_q <= cmpc_pkg::IRQ_RESET;
		end else if (i_ce) begin
			ctl_q <= ctl_d;
			pin_dir_q <= pin_dir_d;
			irq_mask_q <= irq_mask_d;
		end
	end

	// ****************************************
	// Result, read latch and wake detection
	// ****************************************
	// Power is taken from the flop so nothing runs until a cycle after reset release.
	assign powered = power_q;
	// Sleep is deliberately absent from the power path so detection survives sleep.
	assign wake_cond = !ctl_q[cmpc_pkg::CTL_WAKE_DIS] && armed_q && i_sleep &&
		(result_q != latched_q);

	always_comb begin
		// Invert select at 1 passes the comparator straight, at 0 inverts it.
		result_d = powered ? (i_cmp_raw ^ ~ctl_q[cmpc_pkg::CTL_INVERT_SEL]) : 1'b0;
		latched_d = latched_q;
		armed_d = armed_q;
		if (rd_en && (rd_idx == cmpc_pkg::IDX_CTRL)) begin
			latched_d = result_q;
			armed_d = 1'b1;
		end
		pin_wake_d = pin_wake_q;
		cmp_wake_d = cmp_wake_q;
		// Software clears by writing zero; a same-cycle event still sets the flag.
		if (status_wr && !wr_data[cmpc_pkg::STAT_CMP_WAKE]) begin
			cmp_wake_d = 1'b0;
		end
		if (status_wr && !wr_data[cmpc_pkg::STAT_PIN_WAKE]) begin
			pin_wake_d = 1'b0;
		end
		if (wake_cond) begin
			cmp_wake_d = 1'b1;
		end
		if (i_pin_change_wake) begin
			pin_wake_d = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			result_q <= 1'b0;
			latched_q <= 1'b0;
			armed_q <= 1'b0;
			cmp_wake_q <= 1'b0;
			pin_wake_q <= 1'b0;
		end else if (i_ce) begin
			result_q <= result_d;
			latched_q <= latched_d;
			armed_q <= armed_d;
			cmp_wake_q <= cmp_wake_d;
			pin_wake_q <= pin_wake_d;
		end
	end

	// ****************************************
	// Interrupt status and mask
	// ****************************************
	assign irq_ev[cmpc_pkg::IRQ_WAKE] = wake_cond && !cmp_wake_q;
	assign irq_ev[cmpc_pkg::IRQ_CHANGE] = powered && (result_d != result_q);

	always_comb begin
		irq_st_d = irq_st_q;
		if (wr_en && (wr_idx == cmpc_pkg::IDX_IRQ_STATUS)) begin
			irq_st_d = irq_st_q & ~wr_data[cmpc_pkg::IRQ_W-1:0];
		end
		irq_st_d = irq_st_d | irq_ev;
		irq_d = |(irq_st_d & irq_mask_d);
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			irq_st_q <= cmpc_pkg::IRQ_RESET;
			irq_q <= 1'b0;
		end else if (i_ce) begin
			irq_st_q <= irq_st_d;
			irq_q <= irq_d;
		end
	end

	// ****************************************
	// Analog controls and output pin
	// ****************************************
	always_comb begin
		power_d = ctl_q[cmpc_pkg::CTL_POWER_ON];
		pref_d = power_d && ctl_q[cmpc_pkg::CTL_POS_REF];
		nref_d = power_d && ctl_q[cmpc_pkg::CTL_NEG_REF];
		analog_d = 1'b0;
		if (power_d && !ctl_q[cmpc_pkg::CTL_DRIVE_OFF]) begin
			pin_o_d = result_q;
			pin_oe_d = 1'b1;
		end else begin
			pin_o_d = i_pin_port_data;
			pin_oe_d = !pin_dir_q[cmpc_pkg::PIN_DIR_RESULT_BIT];
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			power_q <= 1'b0;
			pref_q <= 1'b0;
			nref_q <= 1'b0;
			analog_q <= 1'b1;
			pin_o_q <= 1'b0;
			pin_oe_q <= 1'b0;
		end else if (i_ce) begin
			power_q <= power_d;
			pref_q <= pref_d;
			nref_q <= nref_d;
			analog_q <= analog_d;
			pin_o_q <= pin_o_d;
			pin_oe_q <= pin_oe_d;
		end
	end

	// ****************************************
	// Timer clock source
	// ****************************************
	cmpc_clk_mux u_clk_mux (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_ce(i_ce),
		.i_timer_clock_select(i_timer_clock_select),
		.i_comparator_clock_select(ctl_q[cmpc_pkg::CTL_CLOCK_SEL]),
		.i_result_pin_drive_off(ctl_q[cmpc_pkg::CTL_DRIVE_OFF]),
		.i_powered(powered),
		.i_instr_tick(i_instr_tick),
		.i_result(result_q),
		.i_ext_pin(i_external_timer_clock_pin),
		.o_timer_clk(o_timer_clk),
		.o_src(src_unused)
	);

	assign o_comparator_power_on = power_q;
	assign o_positive_reference_select = pref_q;
	assign o_negative_reference_select = nref_q;
	assign o_analog_pins = analog_q;
	assign o_comparator_output_pin_o = pin_o_q;
	assign o_comparator_output_pin_oe = pin_oe_q;
	assign o_irq = irq_q;
endmodule

// >>> tb/cmpc_analog_model.sv
// Behavioural model of the analog comparator in front of the control logic.
`timescale 1ns/1ps
module cmpc_analog_model #(
	parameter int SETTLE = 6
) (
	// Clock
	input wire logic i_clk,
	// Analog levels and controls
	input wire logic [7:0] i_pos,
	input wire logic [7:0] i_neg,
	input wire logic i_power_on,
	input wire logic i_pos_sel,
	input wire logic i_neg_sel,
	// Decision
	output logic o_raw
);
	int cnt = SETTLE;
	logic tog_q = 1'h0;
	logic [2:0] mode_q = 3'h0;
	// An unpowered or settling comparator gives no trustworthy level, so it toggles.
	always @(posedge i_clk) begin
		tog_q <= ~tog_q;
		mode_q <= {i_power_on, i_pos_sel, i_neg_sel};
		if (mode_q != {i_power_on, i_pos_sel, i_neg_sel} || !i_power_on) begin
			cnt <= SETTLE;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
		end
	end
	assign o_raw = (cnt > 0) ? tog_q : (i_pos > i_neg);
endmodule

// >>> tb/cmpc_checker.sv
// Port-level assertions for the comparator control logic.
`timescale 1ns/1ps
module cmpc_checker (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Register bus
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// Comparator, timer and pin
	input wire logic o_comparator_power_on,
	input wire logic o_positive_reference_select,
	input wire logic o_negative_reference_select,
	input wire logic o_analog_pins,
	input wire logic i_timer_clock_select,
	input wire logic i_instr_tick,
	input wire logic i_external_timer_clock_pin,
	input wire logic o_timer_clk,
	input wire logic i_pin_port_data,
	input wire logic o_comparator_output_pin_o,
	input wire logic o_comparator_output_pin_oe,
	input wire logic o_irq
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	// ****
	// Properties
	// ****
	property p_tmr_instr;
		!i_timer_clock_select |=> o_timer_clk == $past(i_instr_tick);
	endproperty
	a_tmr_instr: assert property (p_tmr_instr) else $error("timer clock ignores instruction tick");
	property p_tmr_off;
		i_timer_clock_select && !o_comparator_power_on ##1 !o_comparator_power_on
			|-> o_timer_clk == $past(i_external_timer_clock_pin);
	endproperty
	a_tmr_off: assert property (p_tmr_off) else $error("timer clock not external while off");
	property p_ref_off;
		!o_comparator_power_on |-> !o_positive_reference_select && !o_negative_reference_select;
	endproperty
	a_ref_off: assert property (p_ref_off) else $error("reference select active while off");
	property p_pin_off;
		!o_comparator_power_on ##1 !o_comparator_power_on |-> o_comparator_output_pin_o == $past(i_pin_port_data);
	endproperty
	a_pin_off: assert property (p_pin_off) else $error("output pin not port data while off");
	property p_analog;
		disable iff (1'b0) !i_rstn |=> o_analog_pins;
	endproperty
	a_analog: assert property (p_analog) else $error("pins not analog after reset");
	property p_pwr;
		disable iff (1'b0) !i_rstn |=> !o_comparator_power_on;
	endproperty
	a_pwr: assert property (p_pwr) else $error("comparator powered during reset");
	property p_rd_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_rd_up;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_rd_up: assert property (p_rd_up) else $error("upper read data not zero");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	c_irq: cover property ($rose(o_irq));
	c_drive: cover property (o_comparator_power_on && o_comparator_output_pin_oe);
	c_ext: cover property (i_timer_clock_select && !o_comparator_power_on);
endmodule
bind cmpc_top cmpc_checker u_chk (.i_clk, .i_rstn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .o_comparator_power_on,
	.o_positive_reference_select, .o_negative_reference_select, .o_analog_pins, .i_timer_clock_select,
	.i_instr_tick, .i_external_timer_clock_pin, .o_timer_clk, .i_pin_port_data,
	.o_comparator_output_pin_o, .o_comparator_output_pin_oe, .o_irq);

// >>> tb/tb_cmpc_top.sv
// Self-checking bench for the comparator control logic.
`timescale 1ns/1ps
module tb_cmpc_top;
	logic i_clk = 1'h0, i_rstn = 1'h0, i_ce = 1'h1, res = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, pos = 8'h80, neg = 8'h40;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, i_sleep = 1'h0, i_pin_change_wake = 1'h0, i_timer_clock_select = 1'h0;
	logic i_instr_tick = 1'h0, i_external_timer_clock_pin = 1'h0, i_pin_port_data = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, i_cmp_raw;
	logic o_comparator_power_on, o_positive_reference_select, o_negative_reference_select, o_analog_pins;
	logic o_timer_clk, o_comparator_output_pin_o, o_comparator_output_pin_oe, o_irq;
	int failures = 0, num_checks = 0;
	initial begin
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) i_instr_tick <= ~i_instr_tick;
	cmpc_top DUT (.i_clk, .i_rstn, .i_ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .i_cmp_raw, .o_comparator_power_on, .o_positive_reference_select,
		.o_negative_reference_select, .o_analog_pins, .i_sleep, .i_pin_change_wake, .i_timer_clock_select,
		.i_instr_tick, .i_external_timer_clock_pin, .o_timer_clk, .i_pin_port_data,
		.o_comparator_output_pin_o, .o_comparator_output_pin_oe, .o_irq);
	cmpc_analog_model u_ana (.i_clk, .i_pos(pos), .i_neg(neg), .i_power_on(o_comparator_power_on),
		.i_pos_sel(o_positive_reference_select), .i_neg_sel(o_negative_reference_select), .o_raw(i_cmp_raw));
	// ****
	// Tasks
	// ****
	task automatic end_sim();
		if (failures == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk_d(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_b(input logic got, input logic exp);
		chk_d({31'h0, got}, {31'h0, exp});
	endtask
	task automatic tmo(input logic pend);
		if (pend) begin
			failures++;
			end_sim();
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		logic a = 1'h1, w = 1'h1, b = 1'h1;
		int n;
		@(posedge i_clk);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 50 && b; n++) begin
			@(posedge i_clk);
			if (a && s_axi_awready) begin
				a = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w && s_axi_wready) begin
				w = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
			if (b && s_axi_bvalid) begin
				b = 1'h0;
				s_axi_bready <= 1'h0;
				chk_d({30'h0, s_axi_bresp}, (idx inside {6'h03, 6'h07, 6'h08, 6'h09, 6'h0a}) ? 32'h0 : 32'h3);
			end
		end
		tmo(b);
	endtask
	task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [1:0] er);
		logic a = 1'h1, b = 1'h1;
		int n;
		@(posedge i_clk);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 50 && b; n++) begin
			@(posedge i_clk);
			if (a && s_axi_arready) begin
				a = 1'h0;
				s_axi_arvalid <= 1'h0;
			end
			if (b && s_axi_rvalid) begin
				b = 1'h0;
				s_axi_rready <= 1'h0;
				chk_d(s_axi_rdata, {24'h0, exp});
				chk_d({30'h0, s_axi_rresp}, {30'h0, er});
			end
		end
		tmo(b);
	endtask
	// Latching read, then an input swap that flips the result; returns with the status read.
	task automatic wake(input logic [7:0] ctl, input logic slp, input logic [7:0] exp);
		wr(6'h07, ctl);
		rd(6'h07, {res, ctl[6:0]}, 2'h0);
		i_sleep <= slp;
		pos <= neg;
		neg <= pos;
		res = ~res;
		wt(4);
		i_sleep <= 1'h0;
		rd(6'h03, exp, 2'h0);
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		wt(20);
		i_rstn <= 1'h1;
		wt(14);
		rd(6'h07, 8'hff, 2'h0);
		rd(6'h08, 8'h0f, 2'h0);
		rd(6'h0a, 8'h00, 2'h0);
		rd(6'h3f, 8'h00, 2'h3);
		wr(6'h3f, 8'h00);
		wr(6'h07, 8'h7e);
		rd(6'h07, 8'hfe, 2'h0);
		wake(8'hff, 1'h1, 8'h00);
		wake(8'hfe, 1'h0, 8'h00);
		wake(8'hfe, 1'h1, 8'h40);
		chk_b(o_irq, 1'h0);
		wr(6'h0a, 8'h01);
		wt(3);
		chk_b(o_irq, 1'h1);
		i_pin_change_wake <= 1'h1;
		wt(1);
		i_pin_change_wake <= 1'h0;
		rd(6'h03, 8'hc0, 2'h0);
		rd(6'h09, 8'h03, 2'h0);
		wr(6'h03, 8'h00);
		wr(6'h09, 8'h03);
		wt(3);
		chk_b(o_irq, 1'h0);
		rd(6'h03, 8'h00, 2'h0);
		rd(6'h09, 8'h00, 2'h0);
		i_pin_port_data <= 1'h1;
		wr(6'h07, 8'hbe);
		wt(3);
		chk_b(o_comparator_output_pin_oe, 1'h1);
		chk_b(o_comparator_output_pin_o, res);
		wr(6'h07, 8'hb6);
		wt(3);
		chk_b(o_comparator_output_pin_oe, 1'h0);
		wr(6'h08, 8'h0b);
		wt(3);
		chk_b(o_comparator_output_pin_oe, 1'h1);
		chk_b(o_comparator_output_pin_o, 1'h1);
		wr(6'h07, 8'hfe);
		wt(12);
		i_timer_clock_select <= 1'h1;
		i_external_timer_clock_pin <= ~res;
		wt(3);
		chk_b(o_timer_clk, ~res);
		wr(6'h07, 8'hee);
		wt(3);
		chk_b(o_timer_clk, res);
		pos <= neg;
		neg <= pos;
		res = ~res;
		wt(4);
		chk_b(o_timer_clk, res);
		wr(6'h07, 8'hce);
		wt(3);
		chk_b(o_timer_clk, ~res);
		i_rstn <= 1'h0;
		wt(3);
		chk_b(o_comparator_power_on, 1'h0);
		chk_b(o_analog_pins, 1'h1);
		i_rstn <= 1'h1;
		wt(14);
		rd(6'h07, 8'hff, 2'h0);
		end_sim();
	end
endmodule
